// ---- hdl/sfss_pattern_reg.sv ----
// Run-time loadable scrambling pattern register, twenty bytes.
// Assumes byte writes come from logic on the same clock.
`timescale 1ns/1ps
`include "sfss_defs.svh"
module sfss_pattern_reg (
  input wire logic clk_i, // Word clock
  input wire logic srst_i, // Synchronous reset
  input wire logic wr_i, // Byte write strobe
  input wire logic [4:0] addr_i, // Byte index
  input wire logic [7:0] data_i, // Byte to load
  output logic [`SFSS_SCR_LEN-1:0] pattern_o // Pattern, bit 0 first
);
  localparam int NB = `SFSS_PAT_BYTES;
  localparam int BW = `SFSS_BYTE_W;

  logic [BW-1:0] mem_q [NB];
  logic [BW*NB-1:0] flat;

  // Seven-stage generator, feedback from stages six and seven
  function automatic logic [BW*NB-1:0] gen_pattern();
    logic [6:0] s;
    logic [BW*NB-1:0] p;
    s = `SFSS_PAT_SEED;
    p = '0;
    // Seed is stepped once before the first output bit
    for (int i = 0; i < `SFSS_SCR_LEN; i++) begin
      s = {s[5:0], s[6] ^ s[5]};
      p[i] = s[6];
    end
    return p;
  endfunction

  localparam logic [BW*NB-1:0] INIT = gen_pattern();

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      for (int i = 0; i < NB; i++) begin
        mem_q[i] <= INIT[BW*i +: BW];
      end
    end else if (wr_i && (addr_i < 5'(NB))) begin
      mem_q[addr_i] <= data_i;
    end
  end

  always_comb begin
    flat = '0;
    for (int i = 0; i < NB; i++) begin
      flat[BW*i +: BW] = mem_q[i];
    end
  end

  assign pattern_o = flat[`SFSS_SCR_LEN-1:0];
endmodule

// ---- hdl/sfss_top.sv ----
// Frame formatter, frame sync receivers and channel deskew for a 160-bit frame.
// Assumes deserialised 16-bit words on clk_i, word bit 0 earliest on the line.
// Operation
// - Ten-bit sync word in two fixed places
// - Six sync bits at frame bits zero up
// - Word selector reorders; sync finds start, shuffle
// - Search: test candidate, else shift one bit
// - No offset matched: retry with other shuffle
// - Match needs all ten sync bits
// - Check: seven of eight good, else search
// - Monitor: two errors in eight, search again
// - Search resumes from present shift value
// - Compare counts, delay early channels to align
// - Index plus count: meta-frame of two frames
// - Eight checksum bits over preceding 152 bits
// - All but sync bits and index bit 6 scrambled modulo two
// - Pattern starts at eighth bit, 153 long
// - Pattern from seven-stage generator, 1+X^6+X^7
// - Generator seeded with hexadecimal 46
// - Pattern holds 77 ones, 76 zeros
// - Parallel scrambling from loadable 20-byte register
// - Index, count, time, valid, spare, checksum fields
// - Payload at even bits 12..18, then 124 from 20
`timescale 1ns/1ps
`include "sfss_defs.svh"
module sfss_top #(
  parameter int NCH = 3, // Channels per polarisation
  parameter logic [9:0] SYNC = `SFSS_SYNC_PAT // Sync word
) (
  input wire logic clk_i, // Word clock
  input wire logic srst_i, // Synchronous reset
  input wire logic [`SFSS_PAY_W-1:0] tx_payload_i, // Payload for next frame
  input wire logic tx_pps_i, // One second pulse bit
  input wire logic tx_p10s_i, // Ten second pulse bit
  input wire logic tx_dv_i, // Data valid bit
  input wire logic [`SFSS_SPARE_W-1:0] tx_spare_i, // Spare bits
  output logic tx_take_o, // Payload sampled this cycle
  output logic [`SFSS_WORD_W-1:0] tx_word_o, // Formatted word out
  output logic tx_sof_o, // Word 0 of a frame
  input wire logic [NCH-1:0][`SFSS_WORD_W-1:0] rx_word_i, // Deserialised words
  input wire logic pat_wr_i, // Pattern byte write
  input wire logic [4:0] pat_addr_i, // Pattern byte index
  input wire logic [7:0] pat_data_i, // Pattern byte
  output logic [NCH-1:0] locked_o, // Channel in monitor stage
  output logic [NCH-1:0] shuffle_o, // Alternate shuffle in use
  output logic [NCH-1:0] sync_err_o, // Sync miss pulse
  output logic [NCH-1:0] csum_err_o, // Checksum mismatch pulse
  output logic al_valid_o, // Aligned frames pulse
  output logic [`SFSS_KEY_W-1:0] al_key_o, // Count and index of aligned set
  output logic [NCH-1:0] al_skew_o, // Channel held back a frame
  output logic [NCH-1:0][`SFSS_FRAME_W-1:0] al_frame_o // Descrambled frames
);
  localparam int FW = `SFSS_FRAME_W;
  localparam int WW = `SFSS_WORD_W;
  localparam int HW = `SFSS_HIST_W;
  localparam int CP = `SFSS_CSUM_POS;
  localparam int CW = `SFSS_CSUM_W;
  localparam int KW = `SFSS_KEY_W;
  localparam int SH = `SFSS_SYNC_HI_POS;
  localparam int LW = `SFSS_SYNC_LO_W;

  logic [`SFSS_SCR_LEN-1:0] pattern;
  logic [FW-1:0] mask;
  logic [3:0] wc_q;
  logic tick;
  logic tick_d_q;

  sfss_pattern_reg u_pat (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .wr_i(pat_wr_i),
    .addr_i(pat_addr_i),
    .data_i(pat_data_i),
    .pattern_o(pattern)
  );

  // Sync word check, both parts
  function automatic logic sync_ok(input logic [FW-1:0] f);
    return (f[LW-1:0] == SYNC[LW-1:0]) &&
           (f[SH +: `SFSS_SYNC_HI_W] == SYNC[9:LW]);
  endfunction

  // Bit i belongs to group i mod 8
  function automatic logic [CW-1:0] csum(input logic [FW-1:0] f);
    logic [CW-1:0] c;
    c = '0;
    for (int i = 0; i < CP; i++) begin
      c[i % CW] = c[i % CW] ^ f[i];
    end
    return c;
  endfunction

  // Pattern placed from the eighth bit, sync positions left clear
  function automatic logic [FW-1:0] scr_mask(input logic [`SFSS_SCR_LEN-1:0] p);
    logic [FW-1:0] m;
    m = '0;
    for (int k = 0; k < `SFSS_SCR_LEN; k++) begin
      m[`SFSS_SCR_START + k] = p[k];
    end
    m[SH +: `SFSS_SYNC_HI_W] = '0;
    return m;
  endfunction

  function automatic logic [KW-1:0] key_of(input logic [FW-1:0] f);
    return {f[`SFSS_SEQ_POS +: `SFSS_SEQ_W], f[`SFSS_META_POS]};
  endfunction

  function automatic logic [3:0] pop8(input logic [7:0] v);
    logic [3:0] n;
    n = '0;
    for (int i = 0; i < 8; i++) begin
      n = n + {3'h0, v[i]};
    end
    return n;
  endfunction

  assign mask = scr_mask(pattern);
  assign tick = (wc_q == `SFSS_LAST_WORD);

  // Frame word counter shared by both directions
  always_ff @(posedge clk_i) begin
    if (srst_i || tick) begin
      wc_q <= '0;
    end else begin
      wc_q <= wc_q + 4'h1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      tick_d_q <= 1'b0;
    end else begin
      tick_d_q <= tick;
    end
  end

  // ---- Transmit formatter ----
  logic meta_q;
  logic [`SFSS_SEQ_W-1:0] seq_q;
  logic [FW-1:0] tx_plain;
  logic [FW-1:0] tx_frame;
  logic [FW-1:0] tx_sh_q;
  logic [WW-1:0] tx_word_q;
  logic tx_sof_q;

  always_comb begin
    tx_plain = '0;
    tx_plain[LW-1:0] = SYNC[LW-1:0];
    tx_plain[SH +: `SFSS_SYNC_HI_W] = SYNC[9:LW];
    tx_plain[`SFSS_META_POS] = meta_q;
    tx_plain[`SFSS_SEQ_POS +: `SFSS_SEQ_W] = seq_q;
    for (int i = 0; i < `SFSS_PAY_HEAD_N; i++) begin
      tx_plain[`SFSS_PAY_HEAD_POS + 2 * i] = tx_payload_i[i];
    end
    tx_plain[`SFSS_PAY_BODY_POS +: `SFSS_PAY_BODY_N] =
      tx_payload_i[`SFSS_PAY_W-1:`SFSS_PAY_HEAD_N];
    tx_plain[`SFSS_PPS_POS] = tx_pps_i;
    tx_plain[`SFSS_P10S_POS] = tx_p10s_i;
    tx_plain[`SFSS_DV_POS] = tx_dv_i;
    tx_plain[`SFSS_SPARE_LO_POS] = tx_spare_i[0];
    tx_plain[`SFSS_SPARE_HI_POS +: `SFSS_SPARE_W-1] = tx_spare_i[`SFSS_SPARE_W-1:1];
    tx_plain[CP +: CW] = csum(tx_plain);
    tx_frame = tx_plain ^ mask;
  end

  assign tx_take_o = tick;

  // Index alternates per frame; count steps once per meta-frame
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      meta_q <= 1'b0;
      seq_q <= '0;
    end else if (tick) begin
      meta_q <= ~meta_q;
      if (meta_q) begin
        seq_q <= seq_q + 5'h01;
      end
    end
  end

  // Word 0 carries frame bits 15..0
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      tx_sh_q <= '0;
      tx_word_q <= '0;
      tx_sof_q <= 1'b0;
    end else if (tick) begin
      tx_sh_q <= {{WW{1'b0}}, tx_frame[FW-1:WW]};
      tx_word_q <= tx_frame[WW-1:0];
      tx_sof_q <= 1'b1;
    end else begin
      tx_sh_q <= {{WW{1'b0}}, tx_sh_q[FW-1:WW]};
      tx_word_q <= tx_sh_q[WW-1:0];
      tx_sof_q <= 1'b0;
    end
  end

  assign tx_word_o = tx_word_q;
  assign tx_sof_o = tx_sof_q;

  // ---- Receive channels ----
  logic [FW-1:0] cur_q [NCH];
  logic [FW-1:0] prev_q [NCH];
  logic [NCH-1:0] cv_q;
  logic [NCH-1:0] pv_q;
  logic [NCH-1:0] lock_q;
  logic [NCH-1:0] shuf_q;
  logic [NCH-1:0] serr_q;
  logic [NCH-1:0] cerr_q;

  for (genvar c = 0; c < NCH; c++) begin : g_rx
    sfss_pkg::sfss_sync_t st_q;
    logic [HW-1:0] hist_q;
    logic [7:0] shift_q;
    logic [3:0] frames_q;
    logic [3:0] good_q;
    logic [7:0] errwin_q;
    logic [7:0] errwin_n;
    logic [WW-1:0] w_sel;
    logic [FW-1:0] cand;
    logic [FW-1:0] plain;
    logic match;

    // Alternate arrangement reverses the word; a byte swap aliases the sync places
    always_comb begin
      for (int i = 0; i < WW; i++) begin
        w_sel[i] = shuf_q[c] ? rx_word_i[c][WW-1-i] : rx_word_i[c][i];
      end
    end
    assign cand = hist_q[shift_q +: FW];
    assign plain = cand ^ mask;
    assign match = sync_ok(cand);
    assign errwin_n = {errwin_q[6:0], ~match};

    always_ff @(posedge clk_i) begin
      if (srst_i) begin
        hist_q <= '0;
      end else begin
        hist_q <= {w_sel, hist_q[HW-1:WW]};
      end
    end

    always_ff @(posedge clk_i) begin
      if (srst_i) begin
        st_q <= sfss_pkg::SFSS_SEARCH;
        shift_q <= '0;
        shuf_q[c] <= 1'b0;
        frames_q <= '0;
        good_q <= '0;
        errwin_q <= '0;
      end else if (tick) begin
        unique case (st_q)
          sfss_pkg::SFSS_SEARCH: begin
            frames_q <= '0;
            good_q <= '0;
            if (match) begin
              st_q <= sfss_pkg::SFSS_CHECK;
            end else if (shift_q == `SFSS_SHIFT_LAST) begin
              shift_q <= '0;
              shuf_q[c] <= ~shuf_q[c];
            end else begin
              shift_q <= shift_q + 8'h01;
            end
          end
          sfss_pkg::SFSS_CHECK: begin
            frames_q <= frames_q + 4'h1;
            good_q <= good_q + {3'h0, match};
            if (frames_q == `SFSS_CHECK_FRAMES - 4'h1) begin
              if (good_q + {3'h0, match} >= `SFSS_CHECK_MIN) begin
                st_q <= sfss_pkg::SFSS_MONITOR;
                errwin_q <= '0;
              end else begin
                st_q <= sfss_pkg::SFSS_SEARCH;
              end
            end
          end
          sfss_pkg::SFSS_MONITOR: begin
            errwin_q <= errwin_n;
            if ((!match && errwin_q[0]) || (pop8(errwin_n) >= `SFSS_MON_MAX_ERR)) begin
              st_q <= sfss_pkg::SFSS_SEARCH;
              errwin_q <= '0;
            end
          end
          default: begin
            st_q <= sfss_pkg::SFSS_SEARCH;
          end
        endcase
      end
    end

    // Status pulses and captured frames
    always_ff @(posedge clk_i) begin
      if (srst_i) begin
        serr_q[c] <= 1'b0;
        cerr_q[c] <= 1'b0;
        cur_q[c] <= '0;
        prev_q[c] <= '0;
        cv_q[c] <= 1'b0;
        pv_q[c] <= 1'b0;
      end else if (tick) begin
        serr_q[c] <= (st_q != sfss_pkg::SFSS_SEARCH) && !match;
        cerr_q[c] <= (st_q == sfss_pkg::SFSS_MONITOR) &&
                     (csum(plain) != plain[CP +: CW]);
        prev_q[c] <= cur_q[c];
        cur_q[c] <= plain;
        pv_q[c] <= cv_q[c];
        cv_q[c] <= (st_q == sfss_pkg::SFSS_MONITOR) && match;
      end else begin
        serr_q[c] <= 1'b0;
        cerr_q[c] <= 1'b0;
      end
    end

    assign lock_q[c] = (st_q == sfss_pkg::SFSS_MONITOR);
  end

  assign locked_o = lock_q;
  assign shuffle_o = shuf_q;
  assign sync_err_o = serr_q;
  assign csum_err_o = cerr_q;

  // ---- Channel deskew ----
  logic [KW-1:0] key;
  logic key_ok;
  logic al_valid_q;
  logic [KW-1:0] al_key_q;
  logic [NCH-1:0] al_skew_q;
  logic [FW-1:0] al_frame_q [NCH];

  // Newest count held by every channel, taken from the current frames
  always_comb begin
    logic ok;
    ok = 1'b0;
    key = '0;
    key_ok = 1'b0;
    for (int c = 0; c < NCH; c++) begin
      ok = 1'b1;
      for (int d = 0; d < NCH; d++) begin
        if ((key_of(cur_q[d]) != key_of(cur_q[c])) &&
            (key_of(prev_q[d]) != key_of(cur_q[c]))) begin
          ok = 1'b0;
        end
      end
      if (ok && !key_ok) begin
        key_ok = 1'b1;
        key = key_of(cur_q[c]);
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      al_valid_q <= 1'b0;
      al_key_q <= '0;
      al_skew_q <= '0;
    end else if (tick_d_q) begin
      al_valid_q <= key_ok && (&cv_q) && (&pv_q);
      al_key_q <= key;
      for (int c = 0; c < NCH; c++) begin
        al_skew_q[c] <= (key_of(cur_q[c]) != key);
      end
    end else begin
      al_valid_q <= 1'b0;
    end
  end

  for (genvar c = 0; c < NCH; c++) begin : g_al
    always_ff @(posedge clk_i) begin
      if (srst_i) begin
        al_frame_q[c] <= '0;
      end else if (tick_d_q) begin
        al_frame_q[c] <= (key_of(cur_q[c]) == key) ? cur_q[c] : prev_q[c];
      end
    end
    assign al_frame_o[c] = al_frame_q[c];
  end

  assign al_valid_o = al_valid_q;
  assign al_key_o = al_key_q;
  assign al_skew_o = al_skew_q;
endmodule

// ---- include/sfss_defs.svh ----
// Frame layout, pattern and sync timing constants for the frame sync scrambler.
// Assumes a 16-bit parallel word per clock, ten words to a frame.
`ifndef SFSS_DEFS_SVH
`define SFSS_DEFS_SVH
`define SFSS_FRAME_W 160
`define SFSS_WORD_W 16
`define SFSS_BYTE_W 8
`define SFSS_LAST_WORD 4'h9
`define SFSS_HIST_W 320
`define SFSS_SYNC_PAT 10'h13b
`define SFSS_SYNC_LO_W 6
`define SFSS_SYNC_HI_W 4
`define SFSS_SYNC_HI_POS 144
`define SFSS_META_POS 6
`define SFSS_SEQ_POS 7
`define SFSS_SEQ_W 5
`define SFSS_KEY_W 6
`define SFSS_PPS_POS 13
`define SFSS_P10S_POS 15
`define SFSS_DV_POS 17
`define SFSS_SPARE_LO_POS 19
`define SFSS_SPARE_HI_POS 148
`define SFSS_SPARE_W 5
`define SFSS_PAY_HEAD_POS 12
`define SFSS_PAY_HEAD_N 4
`define SFSS_PAY_BODY_POS 20
`define SFSS_PAY_BODY_N 124
`define SFSS_PAY_W 128
`define SFSS_CSUM_POS 152
`define SFSS_CSUM_W 8
`define SFSS_SCR_START 7
`define SFSS_SCR_LEN 153
`define SFSS_PAT_BYTES 20
`define SFSS_PAT_SEED 7'h46
`define SFSS_SHIFT_LAST 8'h9f
`define SFSS_CHECK_FRAMES 4'h8
`define SFSS_CHECK_MIN 4'h7
`define SFSS_MON_MAX_ERR 4'h2
`endif

// ---- include/sfss_pkg.sv ----
// Types shared by the frame sync scrambler files.
// Assumes nothing of its surroundings.
package sfss_pkg;
  typedef enum logic [2:0] {
    SFSS_SEARCH  = 3'b001,
    SFSS_CHECK   = 3'b010,
    SFSS_MONITOR = 3'b100
  } sfss_sync_t;
  typedef logic [159:0] sfss_frame_t;
endpackage

// ---- verification/sfss_far_end.sv ----
// Far end model: three lanes fed from one formatter stream.
// Assumes per-lane word delay, bit order reversal and word 0 upsets set by the bench.
`timescale 1ns/1ps
module sfss_far_end (
  input wire logic clk_i, // Word clock
  input wire logic [15:0] word_i, // Formatted word
  input wire logic sof_i, // Word 0 marker
  input wire logic [2:0][3:0] dly_i, // Word delay per lane
  input wire logic [2:0] swap_i, // Bit order reversal per lane
  input wire logic [2:0] hit_i, // Upset word 0 per lane
  input wire logic [15:0] hit_mask_i, // Upset bits
  output logic [2:0][15:0] word_o // Words to receivers
);
  logic [15:0] line_q [3][16];
  // One source for all lanes keeps counts equal
  always_ff @(posedge clk_i) begin
    for (int c = 0; c < 3; c++) begin
      line_q[c][0] <= word_i ^ ((sof_i && hit_i[c]) ? hit_mask_i : 16'h0000);
      for (int k = 1; k < 16; k++) begin
        line_q[c][k] <= line_q[c][k-1];
      end
    end
  end
  always_comb begin
    for (int c = 0; c < 3; c++) begin
      word_o[c] = line_q[c][dly_i[c]];
      if (swap_i[c]) begin
        for (int b = 0; b < 16; b++) begin
          word_o[c][b] = line_q[c][dly_i[c]][15-b];
        end
      end
    end
  end
endmodule

// ---- verification/sfss_top_asserts.sv ----
// Assertions on sfss_top formatter framing and receiver stage changes.
// Assumes it is bound into sfss_top; stage rules watch one channel each.
`timescale 1ns/1ps
`include "sfss_defs.svh"
module sfss_top_asserts #(
  parameter int NCH = 3, // Channels
  parameter logic [9:0] SYNC = `SFSS_SYNC_PAT // Sync word
) (
  input wire logic clk_i, // Word clock
  input wire logic srst_i, // Sync reset
  input wire logic tx_take_o, // Payload sampled
  input wire logic [`SFSS_WORD_W-1:0] tx_word_o, // Formatted word
  input wire logic tx_sof_o, // Frame start
  input wire logic [NCH-1:0] locked_o, // Monitor stage
  input wire logic [NCH-1:0] shuffle_o, // Alternate shuffle
  input wire logic [NCH-1:0] sync_err_o, // Sync miss
  input wire logic al_valid_o // Aligned set
);
  logic [7:0] low_q;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);
  // Cycles out of monitor stage, saturating
  always_ff @(posedge clk_i) begin
    if (srst_i || locked_o[0]) begin
      low_q <= 8'h00;
    end else if (low_q != 8'hff) begin
      low_q <= low_q + 8'h01;
    end
  end
  take_period_a: assert property (tx_take_o |=> !tx_take_o [*8] ##1 !tx_take_o ##1 tx_take_o)
    else $error("frame is not ten words");
  sof_after_take_a: assert property (tx_take_o |=> tx_sof_o)
    else $error("frame start missing");
  sync_low_a: assert property (tx_sof_o |-> tx_word_o[5:0] == SYNC[5:0])
    else $error("low sync bits wrong");
  sync_high_a: assert property (tx_sof_o |-> ##9 tx_word_o[3:0] == SYNC[9:6])
    else $error("high sync bits wrong");
  meta_toggle_a: assert property (
    tx_sof_o ##10 tx_sof_o |-> tx_word_o[6] != $past(tx_word_o[6], 10))
    else $error("frame index did not toggle");
  check_span_a: assert property ($rose(locked_o[0]) |-> low_q >= 8'h50)
    else $error("lock before eight checked frames");
  drop_on_miss_a: assert property (
    !$past(srst_i) && $fell(locked_o[0]) |-> ##[0:1] sync_err_o[0])
    else $error("lock lost without sync miss");
  miss_at_test_a: assert property (
    sync_err_o[0] |-> $past(tx_take_o) || $past(tx_take_o, 2))
    else $error("sync miss off the test edge");
  aligned_locked_a: assert property (al_valid_o |-> &locked_o)
    else $error("aligned set while unlocked");
  shuffle_search_a: assert property (
    !$past(srst_i) && $changed(shuffle_o[NCH-1]) |-> !locked_o[NCH-1])
    else $error("shuffle changed while locked");
  cover property ($rose(locked_o[0]));
  cover property (al_valid_o);
  cover property ($fell(locked_o[0]));
endmodule
bind sfss_top sfss_top_asserts #(.NCH(NCH), .SYNC(SYNC)) sfss_top_asserts_i (
  .clk_i, .srst_i, .tx_take_o, .tx_word_o, .tx_sof_o, .locked_o, .shuffle_o,
  .sync_err_o, .al_valid_o
);

// ---- verification/sfss_top_bench.sv ----
// Self-checking bench for sfss_top looped back through sfss_far_end.
// Assumes the far end carries the local formatter stream to all receivers.
`timescale 1ns/1ps
`include "sfss_defs.svh"
module sfss_top_bench;
  localparam logic [9:0] SW = `SFSS_SYNC_PAT;
  logic clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic [127:0] pay = '0;
  logic pps = 1'b0;
  logic p10s = 1'b0;
  logic dv = 1'b0;
  logic [4:0] spare = 5'h00;
  logic pat_wr = 1'b0;
  logic [4:0] pat_addr = 5'h00;
  logic [7:0] pat_data = 8'h00;
  // Lane 1 runs a frame behind the others so deskew has work to do
  logic [2:0][3:0] dly = {4'h7, 4'hc, 4'h3};
  logic [2:0] hit = 3'h0;
  logic [15:0] hit_mask = 16'h0000;
  logic take, sof, al_valid;
  logic [15:0] word;
  logic [2:0][15:0] rx_word;
  logic [2:0] locked, shuffle, sync_err, csum_err, al_skew, lk, se, ce;
  logic [5:0] al_key;
  logic [5:0] tx_key = 6'h00;
  logic [2:0][159:0] al_frame;
  logic [152:0] pat;
  sfss_pkg::sfss_frame_t plain [64];
  int num_errors = 0;
  int tests_run = 0;
  int cnt;
  sfss_top sfss_top_i (
    .clk_i(clk_i), .srst_i(srst_i), .tx_payload_i(pay), .tx_pps_i(pps), .tx_p10s_i(p10s),
    .tx_dv_i(dv), .tx_spare_i(spare), .tx_take_o(take), .tx_word_o(word), .tx_sof_o(sof),
    .rx_word_i(rx_word), .pat_wr_i(pat_wr), .pat_addr_i(pat_addr), .pat_data_i(pat_data),
    .locked_o(locked), .shuffle_o(shuffle), .sync_err_o(sync_err), .csum_err_o(csum_err),
    .al_valid_o(al_valid), .al_key_o(al_key), .al_skew_o(al_skew), .al_frame_o(al_frame)
  );
  sfss_far_end sfss_far_end_i (
    .clk_i(clk_i), .word_i(word), .sof_i(sof), .dly_i(dly), .swap_i(3'b100), .hit_i(hit),
    .hit_mask_i(hit_mask), .word_o(rx_word)
  );
  always #50 clk_i = ~clk_i;
  function automatic logic [152:0] gen();
    logic [6:0] s;
    logic [152:0] p;
    s = 7'h46;
    for (int k = 0; k < 153; k++) begin
      s = {s[5:0], s[6] ^ s[5]};
      p[k] = s[6];
    end
    return p;
  endfunction
  function automatic sfss_pkg::sfss_frame_t mk(input logic [5:0] k);
    sfss_pkg::sfss_frame_t f;
    f = '0;
    f[5:0] = SW[5:0];
    f[147:144] = SW[9:6];
    f[6] = k[0];
    f[11:7] = k[5:1];
    for (int i = 0; i < 4; i++) begin
      f[12+2*i] = pay[i];
    end
    f[13] = pps;
    f[15] = p10s;
    f[17] = dv;
    f[19] = spare[0];
    f[143:20] = pay[127:4];
    f[151:148] = spare[4:1];
    for (int i = 0; i < 152; i++) begin
      f[152+i%8] ^= f[i];
    end
    return f;
  endfunction
  function automatic sfss_pkg::sfss_frame_t scr(input sfss_pkg::sfss_frame_t f);
    for (int k = 0; k < 153; k++) begin
      if (k + 7 < 144 || k + 7 > 147) begin
        f[k+7] ^= pat[k];
      end
    end
    return f;
  endfunction
  task automatic chk(input string n, input logic [159:0] seen, input logic [159:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic stop_test();
    if (num_errors == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic tx_frame();
    sfss_pkg::sfss_frame_t f;
    logic [5:0] k;
    for (int n = 0; n < 12 && sof !== 1'b1; n++) @(negedge clk_i);
    k = tx_key - 6'h01;
    for (int w = 0; w < 10; w++) begin
      f[16*w +: 16] = word;
      @(negedge clk_i);
    end
    chk("tx_frame", f, scr(plain[k]));
  endtask
  task automatic upset(input logic [2:0] ch, input logic [15:0] m);
    for (int n = 0; n < 12 && sof !== 1'b1; n++) @(negedge clk_i);
    hit = ch;
    hit_mask = m;
    @(negedge clk_i);
    hit = 3'h0;
  endtask
  task automatic watch(input int n);
    lk = 3'h7;
    se = 3'h0;
    ce = 3'h0;
    repeat (n) begin
      @(negedge clk_i);
      lk &= locked;
      se |= sync_err;
      ce |= csum_err;
    end
  endtask
  // New frame fields at each payload sample, corner payloads first
  always @(negedge clk_i) begin
    if (take === 1'b1) begin
      pay = {$urandom(), $urandom(), $urandom(), $urandom()};
      if (tx_key < 6'h02) pay = {128{tx_key[0]}};
      {pps, p10s, dv, spare} = 8'($urandom());
      plain[tx_key] = mk(tx_key);
      tx_key = tx_key + 6'h01;
    end
  end
  initial begin
    #1000000;
    num_errors++;
    stop_test();
  end
  initial begin
    void'($urandom(32'h8906));
    pat = gen();
    repeat (6) @(negedge clk_i);
    chk("reset", {word, sof, locked, al_valid}, 160'h0);
    srst_i = 1'b0;
    chk("pat_ones", 8'($countones(pat)), 8'h4d);
    repeat (3) tx_frame();
    for (int n = 0; n < 4000 && locked !== 3'h7; n++) @(negedge clk_i);
    chk("lock", {shuffle, locked}, {3'b100, 3'h7});
    cnt = 0;
    // Two tests after lock before a set is valid, then one every frame
    repeat (60) begin
      @(negedge clk_i);
      if (al_valid === 1'b1) begin
        cnt++;
        for (int c = 0; c < 3; c++) chk("al_frame", al_frame[c], plain[al_key]);
        chk("al_skew", al_skew, 3'b101);
      end
    end
    chk("al_count", 8'(cnt), 8'h04);
    upset(3'b010, 16'h0001);
    watch(40);
    chk("one_miss", {lk, se}, {3'h7, 3'b010});
    upset(3'b001, 16'h1000);
    watch(40);
    chk("csum", {lk, se, ce}, {3'h7, 3'h0, 3'b001});
    upset(3'b001, 16'h0001);
    upset(3'b001, 16'h0001);
    watch(20);
    chk("two_miss", lk[0], 1'b0);
    for (int n = 0; n < 200 && locked !== 3'h7; n++) @(negedge clk_i);
    chk("relock", locked, 3'h7);
    upset(3'b100, 16'h0001);
    watch(25);
    upset(3'b100, 16'h0001);
    watch(20);
    chk("spaced_miss", lk[2], 1'b0);
    pat_wr = 1'b1;
    pat_addr = 5'h05;
    pat_data = 8'($urandom());
    pat[40 +: 8] = pat_data;
    @(negedge clk_i);
    pat_addr = 5'h14;
    pat_data = 8'hff;
    @(negedge clk_i);
    pat_wr = 1'b0;
    @(negedge clk_i);
    tx_frame();
    stop_test();
  end
endmodule
